// [ccc_pkg.sv]
// Package of constants and types for the connection control command block
package ccc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CCC_CMD_OFS = 8'h00;
   localparam logic [7:0] CCC_DEST_IP_OFS = 8'h04;
   localparam logic [7:0] CCC_DEST_PORT_OFS = 8'h08;
   localparam logic [7:0] CCC_REPLY_OFS = 8'h0c;
   localparam logic [7:0] CCC_SETTINGS_OFS = 8'h10;
   localparam logic [7:0] CCC_OVERRIDE_OFS = 8'h14;
   localparam logic [7:0] CCC_PEER_IP_SET_OFS = 8'h18;
   localparam logic [7:0] CCC_PEER_PORT_SET_OFS = 8'h1c;
   localparam logic [7:0] CCC_PEER_IP_OVR_OFS = 8'h20;
   localparam logic [7:0] CCC_PEER_PORT_OVR_OFS = 8'h24;
   localparam logic [7:0] CCC_STATUS_OFS = 8'h28;
   localparam logic [7:0] CCC_ACT_IP_OFS = 8'h2c;
   localparam logic [7:0] CCC_ACT_PORT_OFS = 8'h30;
   localparam logic [7:0] CCC_IRQ_STS_OFS = 8'h34;
   localparam logic [7:0] CCC_IRQ_MASK_OFS = 8'h38;

   // ==========================================================
   // Field positions
   localparam int CCC_CMD_HAS_IP_BIT = 4;
   localparam int CCC_CMD_HAS_PORT_BIT = 5;
   localparam int CCC_SET_TCP_BIT = 0;
   localparam int CCC_SET_ROLE_LSB = 1;
   localparam int CCC_SET_AUTO_BIT = 3;
   localparam int CCC_OVR_TCP_BIT = 0;
   localparam int CCC_OVR_TCP_VLD_BIT = 1;
   localparam int CCC_OVR_ROLE_LSB = 2;
   localparam int CCC_OVR_ROLE_VLD_BIT = 4;
   localparam int CCC_REPLY_VLD_BIT = 8;
   localparam int CCC_IRQ_DONE_BIT = 0;
   localparam int CCC_IRQ_OVF_S_BIT = 1;
   localparam int CCC_IRQ_OVF_E_BIT = 2;

   // ==========================================================
   // Reset values and reply characters
   localparam logic [31:0] CCC_IP_RST = 32'h0000_0000;
   localparam logic [15:0] CCC_PORT_RST = 16'h0000;
   localparam logic [7:0] CCC_REPLY_OK = 8'h41;
   localparam logic [7:0] CCC_REPLY_ERR = 8'h43;
   localparam logic [7:0] CCC_REPLY_REJ = 8'h52;
   localparam logic [7:0] CCC_REPLY_RST = 8'h00;

   // ==========================================================
   // Instruction codes, routing roles and stack actions
   typedef enum logic [1:0] {
      CCC_OP_NONE = 2'b00,
      CCC_OP_OPEN = 2'b01,
      CCC_OP_CLOSE = 2'b10,
      CCC_OP_ABORT = 2'b11
   } ccc_op_t;

   typedef enum logic [1:0] {
      CCC_ROLE_SERVER = 2'b00,
      CCC_ROLE_BOTH = 2'b01,
      CCC_ROLE_CLIENT = 2'b10,
      CCC_ROLE_UNUSED = 2'b11
   } ccc_role_t;

   typedef enum logic [2:0] {
      CCC_ACT_NONE = 3'b000,
      CCC_ACT_TCP_SYN = 3'b001,
      CCC_ACT_UDP_ZERO = 3'b010,
      CCC_ACT_TCP_FIN = 3'b011,
      CCC_ACT_TCP_RST = 3'b100,
      CCC_ACT_UDP_DROP = 3'b101
   } ccc_act_t;
endpackage

// [ccc_conn_ctrl.sv]
// Connection control command interpreter with AHB-Lite register slave
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module ccc_conn_ctrl
   import ccc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   input wire logic link_open,
   input wire logic incoming_accept,
   input wire logic addr_obtained,
   input wire logic ovf_ser_evt,
   input wire logic ovf_eth_evt,
   input wire logic [31:0] peer_ip_actual,
   input wire logic [15:0] peer_port_actual,
   output logic act_valid,
   output logic [2:0] act_op,
   output logic [31:0] act_ip,
   output logic [15:0] act_port,
   output logic led_ovf_ser,
   output logic led_ovf_eth
);
   import ccc_pkg::*;

   // ==========================================================
   // Parameter check
   if (ADDR_W < 8) begin : g_addr_chk
      $error("ccc_conn_ctrl: ADDR_W must be at least 8");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic set_tcp;
      logic [1:0] set_role;
      logic set_auto;
      logic ovr_tcp;
      logic ovr_tcp_vld;
      logic [1:0] ovr_role;
      logic ovr_role_vld;
      logic [31:0] peer_ip_set;
      logic [15:0] peer_port_set;
      logic [31:0] peer_ip_ovr;
      logic [15:0] peer_port_ovr;
      logic [31:0] dest_ip;
      logic [15:0] dest_port;
      logic accepted_since_ovr;
      logic ovf_ser;
      logic ovf_eth;
      logic [7:0] reply;
      logic reply_vld;
      logic [2:0] irq_sts;
      logic [2:0] irq_mask;
      logic act_valid;
      logic [2:0] act_op;
      logic [31:0] act_ip;
      logic [15:0] act_port;
   } ccc_state_t;

   ccc_state_t st_reg;
   ccc_state_t st_next;

   logic addr_ph;
   logic cmd_go;
   ccc_op_t cmd_op;
   logic has_ip;
   logic has_port;
   logic tcp_now;
   logic [1:0] role_now;
   logic bad_fields;
   logic rejected;
   logic [31:0] wdata;
   logic [31:0] rd_mux;

   // ==========================================================
   // Bus decode; the slave never stretches, so every phase is one cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ph = hsel & htrans[1] & hready;
   assign wdata = hwdata;
   assign cmd_go = clk_en & st_reg.dp_wr & (st_reg.dp_addr == CCC_CMD_OFS);
   assign cmd_op = ccc_op_t'(wdata[1:0]);
   assign has_ip = wdata[CCC_CMD_HAS_IP_BIT];
   assign has_port = wdata[CCC_CMD_HAS_PORT_BIT];

   // Values in force: a live override beats the stored setting
   assign tcp_now = st_reg.ovr_tcp_vld ? st_reg.ovr_tcp : st_reg.set_tcp;
   assign role_now = st_reg.ovr_role_vld ? st_reg.ovr_role : st_reg.set_role;

   // Field checks: one field alone, or a zero address or port with both fields given, is bad data
   assign bad_fields = (has_ip != has_port)
      | (has_ip & ((st_reg.dest_ip == CCC_IP_RST) | (st_reg.dest_port == CCC_PORT_RST)));

   // Rejection conditions of an open, all judged before any action
   assign rejected = (st_reg.set_auto & ~addr_obtained)
      | link_open
      | (role_now == CCC_ROLE_SERVER);

   // ==========================================================
   // Read mux, sampled in the address phase so data stands in the data phase
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         CCC_DEST_IP_OFS: rd_mux = st_reg.dest_ip;
         CCC_DEST_PORT_OFS: rd_mux = {16'h0000, st_reg.dest_port};
         CCC_REPLY_OFS: rd_mux = {23'h000000, st_reg.reply_vld, st_reg.reply};
         CCC_SETTINGS_OFS: rd_mux = {28'h0000000, st_reg.set_auto, st_reg.set_role,
                                     st_reg.set_tcp};
         CCC_OVERRIDE_OFS: rd_mux = {27'h0000000, st_reg.ovr_role_vld, st_reg.ovr_role,
                                     st_reg.ovr_tcp_vld, st_reg.ovr_tcp};
         CCC_PEER_IP_SET_OFS: rd_mux = st_reg.peer_ip_set;
         CCC_PEER_PORT_SET_OFS: rd_mux = {16'h0000, st_reg.peer_port_set};
         CCC_PEER_IP_OVR_OFS: rd_mux = st_reg.peer_ip_ovr;
         CCC_PEER_PORT_OVR_OFS: rd_mux = {16'h0000, st_reg.peer_port_ovr};
         // Link flag, two overflow flags, address and accept tracking
         CCC_STATUS_OFS: rd_mux = {27'h0000000, st_reg.accepted_since_ovr, addr_obtained,
                                   st_reg.ovf_eth, st_reg.ovf_ser, link_open};
         CCC_ACT_IP_OFS: rd_mux = peer_ip_actual;
         CCC_ACT_PORT_OFS: rd_mux = {16'h0000, peer_port_actual};
         CCC_IRQ_STS_OFS: rd_mux = {29'h00000000, st_reg.irq_sts};
         CCC_IRQ_MASK_OFS: rd_mux = {29'h00000000, st_reg.irq_mask};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.act_valid = 1'b0;
      st_next.dp_wr = addr_ph & hwrite;
      st_next.dp_addr = haddr[7:0];
      if (addr_ph & ~hwrite) begin
         st_next.rdata = rd_mux;
      end

      // Register writes in the data phase; unmapped words are ignored
      if (st_reg.dp_wr) begin
         unique case (st_reg.dp_addr)
            CCC_DEST_IP_OFS: st_next.dest_ip = wdata;
            CCC_DEST_PORT_OFS: st_next.dest_port = wdata[15:0];
            CCC_SETTINGS_OFS: begin
               st_next.set_tcp = wdata[CCC_SET_TCP_BIT];
               st_next.set_role = wdata[CCC_SET_ROLE_LSB +: 2];
               st_next.set_auto = wdata[CCC_SET_AUTO_BIT];
            end
            CCC_OVERRIDE_OFS: begin
               st_next.ovr_tcp = wdata[CCC_OVR_TCP_BIT];
               st_next.ovr_tcp_vld = wdata[CCC_OVR_TCP_VLD_BIT];
               st_next.ovr_role = wdata[CCC_OVR_ROLE_LSB +: 2];
               st_next.ovr_role_vld = wdata[CCC_OVR_ROLE_VLD_BIT];
            end
            CCC_PEER_IP_SET_OFS: st_next.peer_ip_set = wdata;
            CCC_PEER_PORT_SET_OFS: st_next.peer_port_set = wdata[15:0];
            // A peer address or port override write restarts the accept tracking
            CCC_PEER_IP_OVR_OFS: begin
               st_next.peer_ip_ovr = wdata;
               st_next.accepted_since_ovr = 1'b0;
            end
            CCC_PEER_PORT_OVR_OFS: begin
               st_next.peer_port_ovr = wdata[15:0];
               st_next.accepted_since_ovr = 1'b0;
            end
            CCC_IRQ_STS_OFS: st_next.irq_sts = st_reg.irq_sts & ~wdata[2:0];
            CCC_IRQ_MASK_OFS: st_next.irq_mask = wdata[2:0];
            default: st_next.irq_mask = st_reg.irq_mask;
         endcase
      end

      // Instruction execution: answer in one cycle, never wait on the stack
      if (cmd_go) begin
         unique case (cmd_op)
            CCC_OP_OPEN: begin
               if (bad_fields) begin
                  st_next.reply = CCC_REPLY_ERR;
               end else if (rejected) begin
                  st_next.reply = CCC_REPLY_REJ;
               end else begin
                  st_next.reply = CCC_REPLY_OK;
                  st_next.act_valid = 1'b1;
                  st_next.act_op = tcp_now ? CCC_ACT_TCP_SYN : CCC_ACT_UDP_ZERO;
                  if (has_ip) begin
                     st_next.act_ip = st_reg.dest_ip;
                     st_next.act_port = st_reg.dest_port;
                  end else if (st_reg.accepted_since_ovr) begin
                     st_next.act_ip = st_reg.peer_ip_set;
                     st_next.act_port = st_reg.peer_port_set;
                  end else begin
                     st_next.act_ip = st_reg.peer_ip_ovr;
                     st_next.act_port = st_reg.peer_port_ovr;
                  end
               end
            end
            // Close and abort never refuse, even with no link or a passive one
            CCC_OP_CLOSE, CCC_OP_ABORT: begin
               st_next.reply = CCC_REPLY_OK;
               st_next.act_valid = 1'b1;
               st_next.ovf_ser = 1'b0;
               st_next.ovf_eth = 1'b0;
               if (~tcp_now) begin
                  st_next.act_op = CCC_ACT_UDP_DROP;
               end else if (cmd_op == CCC_OP_CLOSE) begin
                  st_next.act_op = CCC_ACT_TCP_FIN;
               end else begin
                  st_next.act_op = CCC_ACT_TCP_RST;
               end
            end
            default: st_next.reply = CCC_REPLY_ERR;
         endcase
         st_next.reply_vld = 1'b1;
         st_next.irq_sts[CCC_IRQ_DONE_BIT] = 1'b1;
      end

      // Hardware events placed last so a set wins over any clear
      if (incoming_accept) begin
         st_next.accepted_since_ovr = 1'b1;
      end
      if (ovf_ser_evt) begin
         st_next.ovf_ser = 1'b1;
         st_next.irq_sts[CCC_IRQ_OVF_S_BIT] = 1'b1;
      end
      if (ovf_eth_evt) begin
         st_next.ovf_eth = 1'b1;
         st_next.irq_sts[CCC_IRQ_OVF_E_BIT] = 1'b1;
      end
   end

   // ==========================================================
   // State register; clock enable low freezes everything
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.accepted_since_ovr <= 1'b1;
         st_reg.reply <= CCC_REPLY_RST;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs, all from flops except the level interrupt
   assign hrdata = st_reg.rdata;
   assign irq = |(st_reg.irq_sts & st_reg.irq_mask);
   assign act_valid = st_reg.act_valid;
   assign act_op = st_reg.act_op;
   assign act_ip = st_reg.act_ip;
   assign act_port = st_reg.act_port;
   assign led_ovf_ser = st_reg.ovf_ser;
   assign led_ovf_eth = st_reg.ovf_eth;

   // ==========================================================
   // Checks; they assume clk_en stays high across the watched cycles
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic open_go;
   assign open_go = cmd_go & (cmd_op == CCC_OP_OPEN);

   server_reject_a: assert property (
      open_go & ~bad_fields & (role_now == CCC_ROLE_SERVER)
      |=> (st_reg.reply == CCC_REPLY_REJ) && !act_valid)
      else $error("open in server role not rejected");

   busy_reject_a: assert property (
      open_go & ~bad_fields & link_open |=> !act_valid && st_reg.reply == CCC_REPLY_REJ)
      else $error("open while link busy not rejected");

   addr_reject_a: assert property (
      open_go & ~bad_fields & st_reg.set_auto & ~addr_obtained
      |=> st_reg.reply == CCC_REPLY_REJ)
      else $error("open without address not rejected");

   half_fields_a: assert property (
      open_go & (has_ip != has_port) |=> st_reg.reply == CCC_REPLY_ERR && !act_valid)
      else $error("single destination field not flagged");

   open_proto_a: assert property (
      open_go & ~bad_fields & ~rejected
      |=> act_valid && act_op == ($past(tcp_now) ? CCC_ACT_TCP_SYN : CCC_ACT_UDP_ZERO))
      else $error("open issued wrong stack action");

   open_target_a: assert property (
      open_go & ~bad_fields & ~rejected & ~has_ip & ~st_reg.accepted_since_ovr
      |=> act_ip == $past(st_reg.peer_ip_ovr) && act_port == $past(st_reg.peer_port_ovr))
      else $error("open did not use override address");

   teardown_ok_a: assert property (
      cmd_go & (cmd_op inside {CCC_OP_CLOSE, CCC_OP_ABORT})
      |=> st_reg.reply == CCC_REPLY_OK ##1 !act_valid)
      else $error("close or abort not accepted");

   ovf_clear_a: assert property (
      cmd_go & (cmd_op == CCC_OP_CLOSE) & ~ovf_ser_evt & ~ovf_eth_evt
      |=> !led_ovf_ser && !led_ovf_eth)
      else $error("close left overflow flags set");

   abort_rst_a: assert property (
      cmd_go & (cmd_op == CCC_OP_ABORT) & tcp_now |=> act_valid && act_op == CCC_ACT_TCP_RST)
      else $error("abort did not reset tcp link");

   // Teardown choice, open targets, overflow latching and quiet refusals
   close_fin_a: assert property (
      cmd_go & (cmd_op == CCC_OP_CLOSE) & tcp_now |=> act_valid && act_op == CCC_ACT_TCP_FIN)
      else $error("close did not shut tcp link gracefully");

   udp_drop_a: assert property (
      cmd_go & (cmd_op inside {CCC_OP_CLOSE, CCC_OP_ABORT}) & ~tcp_now
      |=> act_valid && act_op == CCC_ACT_UDP_DROP)
      else $error("teardown did not discard udp link");

   stored_target_a: assert property (
      open_go & ~bad_fields & ~rejected & ~has_ip & st_reg.accepted_since_ovr
      |=> act_ip == $past(st_reg.peer_ip_set) && act_port == $past(st_reg.peer_port_set))
      else $error("open did not reload stored peer");

   abort_ovf_a: assert property (
      cmd_go & (cmd_op == CCC_OP_ABORT) & ~ovf_ser_evt & ~ovf_eth_evt
      |=> !led_ovf_ser && !led_ovf_eth)
      else $error("abort left overflow flags set");

   reject_quiet_a: assert property (
      open_go & (bad_fields | rejected)
      |=> !act_valid && act_ip == $past(act_ip) && act_port == $past(act_port))
      else $error("refused open disturbed the link");

   open_reply_a: assert property (
      open_go & ~bad_fields & ~rejected |=> st_reg.reply == CCC_REPLY_OK && st_reg.reply_vld)
      else $error("accepted open gave wrong reply");

   ser_ovf_set_a: assert property (
      clk_en & ovf_ser_evt |=> led_ovf_ser && st_reg.irq_sts[CCC_IRQ_OVF_S_BIT])
      else $error("serial overflow not latched");

   eth_ovf_set_a: assert property (
      clk_en & ovf_eth_evt |=> led_ovf_eth && st_reg.irq_sts[CCC_IRQ_OVF_E_BIT])
      else $error("network overflow not latched");
endmodule

// [ccc_stack_model.sv]
// Behavioural network stack model facing the connection control block
`timescale 1ns/100ps
module ccc_stack_model
   import ccc_pkg::*;
#(
   parameter int DLY = 8,
   parameter logic [31:0] PAS_IP = 32'h0a00_0063,
   parameter logic [15:0] PAS_PORT = 16'h0bb8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic act_valid,
   input wire logic [2:0] act_op,
   input wire logic [31:0] act_ip,
   input wire logic [15:0] act_port,
   input wire logic pas_req,
   output logic link_open,
   output logic incoming_accept,
   output logic [31:0] peer_ip_actual,
   output logic [15:0] peer_port_actual
);
   int cnt;
   logic tgt;
   // ==========================================
   // Link state follows an action DLY cycles late, so replies precede it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_open <= 1'b0;
         incoming_accept <= 1'b0;
         peer_ip_actual <= 32'h0;
         peer_port_actual <= 16'h0;
         cnt <= 0;
         tgt <= 1'b0;
      end else begin
         incoming_accept <= 1'b0;
         if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (cnt == 1) begin
            link_open <= tgt;
         end
         if (act_valid) begin
            cnt <= DLY;
            tgt <= (act_op == CCC_ACT_TCP_SYN) || (act_op == CCC_ACT_UDP_ZERO);
            if ((act_op == CCC_ACT_TCP_SYN) || (act_op == CCC_ACT_UDP_ZERO)) begin
               peer_ip_actual <= act_ip;
               peer_port_actual <= act_port;
            end
         end else if (pas_req) begin
            // Passive open by a remote host
            incoming_accept <= 1'b1;
            link_open <= 1'b1;
            peer_ip_actual <= PAS_IP;
            peer_port_actual <= PAS_PORT;
         end
      end
   end
endmodule

// [tb_connection_control_commands.sv]
// Testbench for the connection control command block
`timescale 1ns/100ps
module tb_connection_control_commands;
   import ccc_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, last_ip;
   logic addr_obtained = 1'b0, ovf_ser_evt = 1'b0, ovf_eth_evt = 1'b0, pas_req = 1'b0;
   logic clk_en = 1'b1;
   logic hreadyout, hresp, irq, link_open, incoming_accept, act_valid, led_ovf_ser, led_ovf_eth;
   logic [31:0] hrdata, peer_ip_actual, act_ip, r;
   logic [15:0] peer_port_actual, act_port, last_port;
   logic [2:0] act_op, last_op;
   int bad_count = 0, n_tests = 0, act_cnt = 0;

   always #50 hclk = ~hclk;

   ccc_conn_ctrl dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
      .link_open(link_open), .incoming_accept(incoming_accept),
      .addr_obtained(addr_obtained), .ovf_ser_evt(ovf_ser_evt), .ovf_eth_evt(ovf_eth_evt),
      .peer_ip_actual(peer_ip_actual), .peer_port_actual(peer_port_actual),
      .act_valid(act_valid), .act_op(act_op), .act_ip(act_ip), .act_port(act_port),
      .led_ovf_ser(led_ovf_ser), .led_ovf_eth(led_ovf_eth));

   ccc_stack_model #(.DLY(8)) stack (.hclk(hclk), .hresetn(hresetn), .act_valid(act_valid),
      .act_op(act_op), .act_ip(act_ip), .act_port(act_port), .pas_req(pas_req),
      .link_open(link_open), .incoming_accept(incoming_accept),
      .peer_ip_actual(peer_ip_actual), .peer_port_actual(peer_port_actual));

   // Record each stack action pulse
   always @(posedge hclk) begin
      if (act_valid === 1'b1) begin
         act_cnt = act_cnt + 1;
         last_op = act_op;
         last_ip = act_ip;
         last_port = act_port;
      end
   end

   // ==========================================
   // Checking and closing report
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // ==========================================
   // Bus master: hold each phase until hready is sampled high
   task automatic wait_rdy();
      int i;
      for (i = 0; i < 20; i++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) begin
            return;
         end
      end
      bad_count++;
      conclude();
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   // Command write, reply check and count of stack actions that followed
   task automatic cmd(input logic [31:0] c, input logic [7:0] ch, input int nact);
      int n0;
      n0 = act_cnt;
      wr(CCC_CMD_OFS, c);
      rd(CCC_REPLY_OFS, {23'h0, 1'b1, ch});
      chk(32'(act_cnt - n0), 32'(nact));
   endtask

   task automatic act_chk(input logic [2:0] op, input logic [31:0] ip, input logic [15:0] pt);
      chk({29'h0, last_op}, {29'h0, op});
      chk(last_ip, ip);
      chk({16'h0, last_port}, {16'h0, pt});
   endtask

   task automatic wait_link(input logic v);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge hclk);
         if (link_open === v) begin
            return;
         end
      end
      bad_count++;
      conclude();
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(CCC_REPLY_OFS, 32'h0);
      rd(CCC_STATUS_OFS, 32'h10);
      rd(8'h3c, 32'h0);
      wr(CCC_SETTINGS_OFS, 32'hb);
      cmd(32'h1, CCC_REPLY_REJ, 0);
      addr_obtained <= 1'b1;
      cmd(32'h11, CCC_REPLY_ERR, 0);
      cmd(32'h21, CCC_REPLY_ERR, 0);
      wr(CCC_DEST_IP_OFS, 32'h0);
      wr(CCC_DEST_PORT_OFS, 32'h5);
      cmd(32'h31, CCC_REPLY_ERR, 0);
      wr(CCC_SETTINGS_OFS, 32'h9);
      cmd(32'h1, CCC_REPLY_REJ, 0);
      wr(CCC_SETTINGS_OFS, 32'hd);
      // Server role through the override beats the client setting
      wr(CCC_OVERRIDE_OFS, 32'h10);
      cmd(32'h1, CCC_REPLY_REJ, 0);
      wr(CCC_OVERRIDE_OFS, 32'h0);
      wr(CCC_DEST_IP_OFS, 32'h0a00_0001);
      wr(CCC_DEST_PORT_OFS, 32'h1f90);
      cmd(32'h31, CCC_REPLY_OK, 1);
      act_chk(CCC_ACT_TCP_SYN, 32'h0a00_0001, 16'h1f90);
      chk({31'h0, link_open}, 32'h0);
      wait_link(1'b1);
      rd(CCC_STATUS_OFS, 32'h19);
      cmd(32'h31, CCC_REPLY_REJ, 0);
      rd(CCC_ACT_IP_OFS, 32'h0a00_0001);
      rd(CCC_ACT_PORT_OFS, 32'h1f90);
      // Both overflow events, then the interrupt through its mask
      ovf_ser_evt <= 1'b1;
      ovf_eth_evt <= 1'b1;
      @(posedge hclk);
      ovf_ser_evt <= 1'b0;
      ovf_eth_evt <= 1'b0;
      rd(CCC_STATUS_OFS, 32'h1f);
      chk({30'h0, led_ovf_ser, led_ovf_eth}, 32'h3);
      rd(CCC_IRQ_STS_OFS, 32'h7);
      chk({31'h0, irq}, 32'h0);
      wr(CCC_IRQ_MASK_OFS, 32'h6);
      @(negedge hclk);
      chk({31'h0, irq}, 32'h1);
      cmd(32'h2, CCC_REPLY_OK, 1);
      act_chk(CCC_ACT_TCP_FIN, 32'h0a00_0001, 16'h1f90);
      chk({30'h0, led_ovf_ser, led_ovf_eth}, 32'h0);
      bus(1'b0, CCC_STATUS_OFS, 32'h0, r);
      chk(r & 32'h6, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wr(CCC_IRQ_STS_OFS, 32'h7);
      @(negedge hclk);
      chk({31'h0, irq}, 32'h0);
      rd(CCC_IRQ_STS_OFS, 32'h0);
      wait_link(1'b0);
      // UDP by override, destination from the peer overrides
      wr(CCC_OVERRIDE_OFS, 32'h2);
      wr(CCC_PEER_IP_SET_OFS, 32'hc0a8_0001);
      wr(CCC_PEER_PORT_SET_OFS, 32'h1234);
      wr(CCC_PEER_IP_OVR_OFS, 32'hc0a8_0002);
      wr(CCC_PEER_PORT_OVR_OFS, 32'h4321);
      cmd(32'h1, CCC_REPLY_OK, 1);
      act_chk(CCC_ACT_UDP_ZERO, 32'hc0a8_0002, 16'h4321);
      wait_link(1'b1);
      cmd(32'h3, CCC_REPLY_OK, 1);
      chk({29'h0, last_op}, {29'h0, CCC_ACT_UDP_DROP});
      wait_link(1'b0);
      // Passive open by a remote host, then stored settings are reloaded
      pas_req <= 1'b1;
      @(posedge hclk);
      pas_req <= 1'b0;
      wait_link(1'b1);
      bus(1'b0, CCC_STATUS_OFS, 32'h0, r);
      chk(r & 32'h11, 32'h11);
      cmd(32'h2, CCC_REPLY_OK, 1);
      chk({29'h0, last_op}, {29'h0, CCC_ACT_UDP_DROP});
      wait_link(1'b0);
      cmd(32'h1, CCC_REPLY_OK, 1);
      act_chk(CCC_ACT_UDP_ZERO, 32'hc0a8_0001, 16'h1234);
      wait_link(1'b1);
      wr(CCC_OVERRIDE_OFS, 32'h0);
      cmd(32'h3, CCC_REPLY_OK, 1);
      chk({29'h0, last_op}, {29'h0, CCC_ACT_TCP_RST});
      wait_link(1'b0);
      cmd(32'h3, CCC_REPLY_OK, 1);
      // Clock enable low must swallow an overflow event
      clk_en <= 1'b0;
      ovf_ser_evt <= 1'b1;
      @(posedge hclk);
      ovf_ser_evt <= 1'b0;
      clk_en <= 1'b1;
      @(negedge hclk);
      chk({31'h0, led_ovf_ser}, 32'h0);
      conclude();
   end
endmodule
